/* pkg/lsf_pkg.sv */
`default_nettype none
package lsf_pkg;
   // ----------------------------------------------------------------
   // Clock and idle timeout
   // ----------------------------------------------------------------
   localparam int unsigned CLK_HZ = 40_000_000;
   localparam int unsigned IDLE_TIMEOUT_S = 4;
   localparam int unsigned IDLE_TIMEOUT_CYC = CLK_HZ * IDLE_TIMEOUT_S;
   localparam int IDLE_CNT_W = 28;

   // ----------------------------------------------------------------
   // Register addresses
   // ----------------------------------------------------------------
   localparam logic [7:0] ADDR_CTRL = 8'h08;
   localparam logic [7:0] ADDR_STAT = 8'h09;
   localparam logic [7:0] ADDR_ERR = 8'h0a;
   localparam logic [7:0] ADDR_EVT = 8'h10;
   localparam logic [7:0] ADDR_MASK = 8'h11;

   // ----------------------------------------------------------------
   // Field positions
   // ----------------------------------------------------------------
   localparam int ST_ACTIVE = 7;
   localparam int ST_IDLE = 6;
   localparam int ST_ABORT = 5;
   localparam int ST_DREQ = 4;
   localparam int ST_PEND = 3;
   localparam int ST_ERROR = 2;
   localparam int ST_WAKE = 1;
   localparam int ST_DONE = 0;
   localparam int CTL_STOP = 7;
   localparam int CTL_DTACK = 4;
   localparam int CTL_CLR_INT = 3;
   localparam int CTL_CLR_ERR = 2;
   localparam int ERR_W = 5;
   localparam int ERR_BIT = 0;
   localparam int ERR_CHK = 1;
   localparam int ERR_TOUT = 2;
   localparam int ERR_PRTY = 3;
   localparam int ERR_SYNC = 4;
   localparam int EV_W = 6;
   localparam int EV_DREQ = 0;
   localparam int EV_DONE = 1;
   localparam int EV_ERR = 2;
   localparam int EV_WAKE = 3;
   localparam int EV_ABORT = 4;
   localparam int EV_IDLE = 5;

   // ----------------------------------------------------------------
   // Reset values
   // ----------------------------------------------------------------
   localparam logic [7:0] RDATA_RST = 8'h00;
   localparam logic [ERR_W-1:0] ERR_RST = 5'h00;
   localparam logic [EV_W-1:0] EV_RST = 6'h00;
   localparam logic [EV_W-1:0] MASK_RST = 6'h00;
   localparam logic [7:0] UNMAPPED_RD = 8'h00;
endpackage
`default_nettype wire

/* pkg/lsf_idle_if.sv */
`timescale 1ns/1ps
`default_nettype none
// Carries bus conditions to the idle timer and its expiry back
interface lsf_idle_if;
   logic bus_active;
   logic slave_mode;
   logic sleep_mode;
   logic expired;
   modport timer (input bus_active, input slave_mode, input sleep_mode, output expired);
   modport core (output bus_active, output slave_mode, output sleep_mode, input expired);
endinterface
`default_nettype wire

/* hdl/lsf_idle_timer.sv */
`timescale 1ns/1ps
`default_nettype none
module lsf_idle_timer #(
   parameter int unsigned IDLE_CYCLES = lsf_pkg::IDLE_TIMEOUT_CYC
) (
   input wire logic clk_sys,
   input wire logic rst,
   lsf_idle_if.timer idle
);
   // ----------------------------------------------------------------
   // State
   // ----------------------------------------------------------------
   typedef struct packed {
      logic [lsf_pkg::IDLE_CNT_W-1:0] cnt;
      logic fired;
      logic pulse;
   } lsf_tmr_t;

   localparam logic [lsf_pkg::IDLE_CNT_W-1:0] LAST =
      lsf_pkg::IDLE_CNT_W'(IDLE_CYCLES - 1);

   lsf_tmr_t s_q;
   lsf_tmr_t s_d;
   logic counting;

   // Only a slave that is awake and sees a quiet bus counts
   assign counting = !idle.bus_active && idle.slave_mode && !idle.sleep_mode;

   // Next state: one pulse per quiet period
   always_comb begin
      s_d = s_q;
      s_d.pulse = 1'b0;
      if (!counting) begin
         s_d.cnt = '0;
         s_d.fired = 1'b0;
      end else if (s_q.cnt == LAST) begin
         if (!s_q.fired) begin
            s_d.pulse = 1'b1;
         end
         s_d.fired = 1'b1;
      end else begin
         s_d.cnt = s_q.cnt + 1'b1;
      end
   end

   // State register
   always_ff @(posedge clk_sys) begin
      if (rst) begin
         s_q <= '0;
      end else begin
         s_q <= s_d;
      end
   end

   assign idle.expired = s_q.pulse;
endmodule // lsf_idle_timer
`default_nettype wire

/* hdl/lsf_status.sv */
// What this block does
// - Bit 7 follows detected bus activity
// - Slave: bit 6 after four quiet seconds
// - Slave: bit 5 on early break or stop
// - Clean break clears the abort flag
// - Slave: bit 4 set when identifier received
// - Bit 3 pending; cleared by interrupt-clear strobe
// - Bit 2 on error; cleared by error-clear strobe
// - Bit 1 while sending or after receiving wakeup
// - Bit 0 set when transfer finishes
// - Bit 0 cleared when a transfer starts
// - Interrupt-clear strobe reads zero, one clears
// - Error-clear strobe clears both error registers
//
// Design decision made here: the strobed register port.
`timescale 1ns/1ps
`default_nettype none
module lsf_status #(
   parameter int unsigned IDLE_CYCLES = lsf_pkg::IDLE_TIMEOUT_CYC
) (
   input wire logic clk_sys,
   input wire logic rst,
   // Register port
   input wire logic [7:0] reg_addr,
   input wire logic [7:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   output logic [7:0] reg_rdata,
   // Mode and bus conditions from the framing engine
   input wire logic slave_mode,
   input wire logic sleep_mode,
   input wire logic bus_active,
   input wire logic break_det,
   input wire logic xfer_busy,
   input wire logic xfer_start,
   input wire logic xfer_done,
   input wire logic id_rcvd,
   input wire logic err_sync,
   input wire logic err_parity,
   input wire logic err_timeout,
   input wire logic err_chksum,
   input wire logic err_bit,
   input wire logic wake_tx,
   input wire logic wake_rx,
   // To the framing engine and processor
   output logic stop_req,
   output logic irq
);
   // ----------------------------------------------------------------
   // State
   // ----------------------------------------------------------------
   typedef struct packed {
      logic active;
      logic idle;
      logic abort;
      logic dreq;
      logic pend;
      logic error;
      logic wake_tx;
      logic wake_seen;
      logic done;
      logic [lsf_pkg::ERR_W-1:0] err;
      logic [lsf_pkg::EV_W-1:0] ev;
      logic [lsf_pkg::EV_W-1:0] mask;
      logic stop;
      logic [7:0] rdata;
   } lsf_state_t;

   lsf_state_t s_q;
   lsf_state_t s_d;

   lsf_idle_if idle_if ();

   logic wr_ctrl;
   logic wr_evt;
   logic wr_mask;
   logic clr_int;
   logic clr_err;
   logic stop_wr;
   logic dtack_wr;
   logic [lsf_pkg::ERR_W-1:0] err_in;
   logic [lsf_pkg::EV_W-1:0] ev_set;
   logic abort_set;
   logic abort_clr;
   logic dreq_set;
   logic [7:0] status;

   // ----------------------------------------------------------------
   // Idle timer
   // ----------------------------------------------------------------
   // Feed the timer with the live bus conditions
   assign idle_if.bus_active = bus_active;
   assign idle_if.slave_mode = slave_mode;
   assign idle_if.sleep_mode = sleep_mode;

   lsf_idle_timer #(
      .IDLE_CYCLES(IDLE_CYCLES)
   ) u_idle (
      .clk_sys(clk_sys),
      .rst(rst),
      .idle(idle_if.timer)
   );

   // ----------------------------------------------------------------
   // Register port decode
   // ----------------------------------------------------------------
   // Write decode by address
   always_comb begin
      wr_ctrl = 1'b0;
      wr_evt = 1'b0;
      wr_mask = 1'b0;
      if (reg_wr && reg_addr == lsf_pkg::ADDR_CTRL) begin
         wr_ctrl = 1'b1;
      end else if (reg_wr && reg_addr == lsf_pkg::ADDR_EVT) begin
         wr_evt = 1'b1;
      end else if (reg_wr && reg_addr == lsf_pkg::ADDR_MASK) begin
         wr_mask = 1'b1;
      end
   end

   // Control strobes act only on a written one
   assign clr_int = wr_ctrl && reg_wdata[lsf_pkg::CTL_CLR_INT];
   assign clr_err = wr_ctrl && reg_wdata[lsf_pkg::CTL_CLR_ERR];
   assign stop_wr = wr_ctrl && reg_wdata[lsf_pkg::CTL_STOP];
   assign dtack_wr = wr_ctrl && reg_wdata[lsf_pkg::CTL_DTACK];

   // ----------------------------------------------------------------
   // Event sources
   // ----------------------------------------------------------------
   // Error detail inputs in register layout
   always_comb begin
      err_in = '0;
      err_in[lsf_pkg::ERR_BIT] = err_bit;
      err_in[lsf_pkg::ERR_CHK] = err_chksum;
      err_in[lsf_pkg::ERR_TOUT] = err_timeout;
      err_in[lsf_pkg::ERR_PRTY] = err_parity && slave_mode;
      err_in[lsf_pkg::ERR_SYNC] = err_sync && slave_mode;
   end

   // Abort sets on early break or stop, clears on clean break
   assign abort_set = slave_mode && ((break_det && xfer_busy) || stop_wr);
   assign abort_clr = break_det && !xfer_busy;
   assign dreq_set = slave_mode && id_rcvd;

   // Events that raise the interrupt
   always_comb begin
      ev_set = '0;
      ev_set[lsf_pkg::EV_DREQ] = dreq_set;
      ev_set[lsf_pkg::EV_DONE] = xfer_done;
      ev_set[lsf_pkg::EV_ERR] = |err_in;
      ev_set[lsf_pkg::EV_WAKE] = wake_rx;
      ev_set[lsf_pkg::EV_ABORT] = abort_set;
      ev_set[lsf_pkg::EV_IDLE] = idle_if.expired;
   end

   // ----------------------------------------------------------------
   // Status byte
   // ----------------------------------------------------------------
   // Live view of the flags as software reads them
   always_comb begin
      status = '0;
      status[lsf_pkg::ST_ACTIVE] = s_q.active;
      status[lsf_pkg::ST_IDLE] = s_q.idle;
      status[lsf_pkg::ST_ABORT] = s_q.abort;
      status[lsf_pkg::ST_DREQ] = s_q.dreq;
      status[lsf_pkg::ST_PEND] = s_q.pend;
      status[lsf_pkg::ST_ERROR] = s_q.error;
      status[lsf_pkg::ST_WAKE] = s_q.wake_tx || s_q.wake_seen;
      status[lsf_pkg::ST_DONE] = s_q.done;
   end

   // ----------------------------------------------------------------
   // Next state
   // ----------------------------------------------------------------
   // Every hardware set wins over a clear in the same cycle
   always_comb begin
      s_d = s_q;

      // Bus activity follows the detector
      s_d.active = bus_active;

      // Idle timeout holds until activity, sleep or leaving slave mode
      if (idle_if.expired && slave_mode) begin
         s_d.idle = 1'b1;
      end else if (bus_active || sleep_mode || !slave_mode) begin
         s_d.idle = 1'b0;
      end

      // Aborted transfer
      if (abort_set) begin
         s_d.abort = 1'b1;
      end else if (abort_clr) begin
         s_d.abort = 1'b0;
      end

      // Data request stays low until an identifier arrives
      if (dreq_set) begin
         s_d.dreq = 1'b1;
      end else if (break_det || dtack_wr || !slave_mode) begin
         s_d.dreq = 1'b0;
      end

      // Interrupt pending on any unmasked event
      if (|(ev_set & s_q.mask)) begin
         s_d.pend = 1'b1;
      end else if (clr_int) begin
         s_d.pend = 1'b0;
      end

      // Communication error and its detail bits
      if (|err_in) begin
         s_d.error = 1'b1;
      end else if (clr_err) begin
         s_d.error = 1'b0;
      end
      if (clr_err) begin
         s_d.err = err_in;
      end else begin
         s_d.err = s_q.err | err_in;
      end

      // Wakeup: sending is a level, reception is remembered
      s_d.wake_tx = wake_tx;
      if (wake_rx) begin
         s_d.wake_seen = 1'b1;
      end else if (break_det) begin
         s_d.wake_seen = 1'b0;
      end

      // Transfer complete
      if (xfer_done) begin
         s_d.done = 1'b1;
      end else if (xfer_start) begin
         s_d.done = 1'b0;
      end

      // Sticky events, write one to clear
      if (wr_evt) begin
         s_d.ev = (s_q.ev & ~reg_wdata[lsf_pkg::EV_W-1:0]) | ev_set;
      end else begin
         s_d.ev = s_q.ev | ev_set;
      end
      if (wr_mask) begin
         s_d.mask = reg_wdata[lsf_pkg::EV_W-1:0];
      end

      // Stop request pulse, slave mode only
      s_d.stop = stop_wr && slave_mode;

      // Read data for the cycle after the strobe
      s_d.rdata = lsf_pkg::UNMAPPED_RD;
      if (reg_rd) begin
         if (reg_addr == lsf_pkg::ADDR_STAT) begin
            s_d.rdata = status;
         end else if (reg_addr == lsf_pkg::ADDR_ERR) begin
            s_d.rdata = {3'h0, s_q.err};
         end else if (reg_addr == lsf_pkg::ADDR_EVT) begin
            s_d.rdata = {2'h0, s_q.ev};
         end else if (reg_addr == lsf_pkg::ADDR_MASK) begin
            s_d.rdata = {2'h0, s_q.mask};
         end else if (reg_addr == lsf_pkg::ADDR_CTRL) begin
            s_d.rdata = lsf_pkg::UNMAPPED_RD; // Strobes read zero
         end
      end
   end

   // ----------------------------------------------------------------
   // State register
   // ----------------------------------------------------------------
   // All flags clear on reset
   always_ff @(posedge clk_sys) begin
      if (rst) begin
         s_q <= '0;
         s_q.err <= lsf_pkg::ERR_RST;
         s_q.ev <= lsf_pkg::EV_RST;
         s_q.mask <= lsf_pkg::MASK_RST;
         s_q.rdata <= lsf_pkg::RDATA_RST;
      end else begin
         s_q <= s_d;
      end
   end

   // ----------------------------------------------------------------
   // Outputs
   // ----------------------------------------------------------------
   assign reg_rdata = s_q.rdata;
   assign stop_req = s_q.stop;
   assign irq = s_q.pend;
endmodule // lsf_status
`default_nettype wire

/* dv/lsf_node_model.sv */
`timescale 1ns/1ps
`default_nettype none
// ----------------------------------------
// Far-side node: one frame per go pulse
// ----------------------------------------
module lsf_node_model (
   input wire logic clk_sys,
   input wire logic go,
   input wire logic [3:0] len,
   output logic bus_active,
   output logic break_det,
   output logic xfer_busy,
   output logic xfer_start,
   output logic id_rcvd,
   output logic xfer_done
);
   logic [4:0] n_q = 5'h00;
   logic busy_q = 1'b0;
   // Frame step counter; a new go restarts it even mid-frame
   always_ff @(posedge clk_sys) begin
      if (go) begin
         n_q <= 5'h01;
      end else if (n_q != 5'h00) begin
         n_q <= xfer_done ? 5'h00 : n_q + 5'h01;
      end
      busy_q <= xfer_start | (busy_q & !xfer_done);
   end
   // Break, start, identifier, data, then completion
   assign break_det = n_q == 5'h01;
   assign xfer_start = n_q == 5'h02;
   assign id_rcvd = n_q == 5'h03;
   assign xfer_done = n_q == 5'(len) + 5'h03;
   assign bus_active = n_q != 5'h00;
   assign xfer_busy = busy_q;
endmodule // lsf_node_model
`default_nettype wire

/* dv/lsf_status_checker.sv */
`timescale 1ns/1ps
`default_nettype none
module lsf_status_checker #(
   parameter int unsigned IDLE_CYCLES = lsf_pkg::IDLE_TIMEOUT_CYC
) (
   input wire logic clk_sys,
   input wire logic rst,
   input wire logic [7:0] reg_addr,
   input wire logic [7:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   input wire logic [7:0] reg_rdata,
   input wire logic slave_mode,
   input wire logic bus_active,
   input wire logic xfer_start,
   input wire logic xfer_done,
   input wire logic err_sync,
   input wire logic err_parity,
   input wire logic err_timeout,
   input wire logic err_chksum,
   input wire logic err_bit,
   input wire logic stop_req,
   input wire logic irq
);
   logic rst_q, done_q, err_q;
   logic [5:0] mask_q;
   // Decoded accesses and error sources
   wire logic ctl_wr = reg_wr && reg_addr == lsf_pkg::ADDR_CTRL;
   wire logic stop_wr = ctl_wr && reg_wdata[7] && slave_mode;
   wire logic st_rd = reg_rd && reg_addr == lsf_pkg::ADDR_STAT && !rst_q;
   wire logic any_err = slave_mode & (err_sync | err_parity) | err_timeout | err_chksum | err_bit;
   // Shadow copies of the done flag, error flag and event mask
   always_ff @(posedge clk_sys) begin
      rst_q <= rst;
      if (rst) begin
         done_q <= 1'b0;
         err_q <= 1'b0;
         mask_q <= 6'h00;
      end else begin
         done_q <= xfer_done | (done_q & !xfer_start);
         err_q <= any_err | (err_q & !(ctl_wr && reg_wdata[2]));
         if (reg_wr && reg_addr == lsf_pkg::ADDR_MASK) mask_q <= reg_wdata[5:0];
      end
   end
   default clocking @(posedge clk_sys); endclocking
   default disable iff (rst);
   property p_active; st_rd |=> reg_rdata[7] == $past(bus_active, 2); endproperty
   a_active: assert property (p_active) else $error("activity bit wrong");
   property p_done; st_rd |=> reg_rdata[0] == $past(done_q); endproperty
   a_done: assert property (p_done) else $error("done bit wrong");
   property p_err; st_rd |=> reg_rdata[2] == $past(err_q); endproperty
   a_err: assert property (p_err) else $error("error bit wrong");
   property p_pend; st_rd |=> reg_rdata[3] == $past(irq); endproperty
   a_pend: assert property (p_pend) else $error("pending bit differs from irq");
   property p_ctl_rd; reg_rd && reg_addr == lsf_pkg::ADDR_CTRL |=> reg_rdata == 8'h00; endproperty
   a_ctl_rd: assert property (p_ctl_rd) else $error("control read not zero");
   property p_clr_int;
      ctl_wr && reg_wdata[3] && mask_q == 6'h02 && !xfer_done |=> !irq;
   endproperty
   a_clr_int: assert property (p_clr_int) else $error("irq not cleared");
   property p_set_int; xfer_done && mask_q[1] |=> irq; endproperty
   a_set_int: assert property (p_set_int) else $error("irq not raised");
   property p_stop; 1'b1 |=> stop_req == $past(stop_wr); endproperty
   a_stop: assert property (p_stop) else $error("stop pulse wrong");
   c_irq: cover property (st_rd && irq);
   c_stop: cover property (stop_req);
   c_done: cover property (xfer_done && mask_q[1]);
endmodule // lsf_status_checker
bind lsf_status lsf_status_checker #(.IDLE_CYCLES(IDLE_CYCLES)) chk (.*);
`default_nettype wire

/* dv/lsf_status_tb.sv */
`timescale 1ns/1ps
`default_nettype none
`define LSF_CHK(a, e) begin total_checks++; if ((a) !== (e)) begin mismatches++; \
   $display("unexpected at %0t: got %h want %h", $time, a, e); end end
module lsf_status_tb;
   logic clk_sys = 1'b0;
   logic rst = 1'b1;
   logic [7:0] reg_addr = 8'h00;
   logic [7:0] reg_wdata = 8'h00;
   logic reg_wr = 1'b0;
   logic reg_rd = 1'b0;
   logic slave_mode = 1'b0;
   logic sleep_mode = 1'b0;
   logic wake_tx = 1'b0;
   logic wake_rx = 1'b0;
   logic go = 1'b0;
   logic rd_d = 1'b0;
   logic [3:0] len = 4'hf;
   logic [4:0] errs = 5'h00;
   logic [4:0] e;
   logic [7:0] reg_rdata;
   logic bus_active, break_det, xfer_busy, xfer_start, id_rcvd, xfer_done, stop_req, irq;
   logic [15:0] q[$];
   logic [15:0] ent;
   int mismatches = 0;
   int total_checks = 0;
   lsf_status #(.IDLE_CYCLES(20)) dut (
      .clk_sys(clk_sys), .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
      .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .slave_mode(slave_mode),
      .sleep_mode(sleep_mode), .bus_active(bus_active), .break_det(break_det),
      .xfer_busy(xfer_busy), .xfer_start(xfer_start), .xfer_done(xfer_done),
      .id_rcvd(id_rcvd), .err_sync(errs[4]), .err_parity(errs[3]), .err_timeout(errs[2]),
      .err_chksum(errs[1]), .err_bit(errs[0]), .wake_tx(wake_tx), .wake_rx(wake_rx),
      .stop_req(stop_req), .irq(irq));
   lsf_node_model node (.clk_sys(clk_sys), .go(go), .len(len), .bus_active(bus_active),
      .break_det(break_det), .xfer_busy(xfer_busy), .xfer_start(xfer_start),
      .id_rcvd(id_rcvd), .xfer_done(xfer_done));
   // ----------------------------------------
   // Clock, bus tasks and read checking
   // ----------------------------------------
   always #12.5 clk_sys = ~clk_sys;
   // Read answers are checked one cycle after the strobe
   always @(posedge clk_sys) rd_d <= reg_rd;
   always @(negedge clk_sys) begin
      if (rd_d) begin
         ent = q.pop_front();
         `LSF_CHK(reg_rdata & ent[15:8], ent[7:0])
      end
   end
   task automatic bus(input logic w, input logic r, input logic [7:0] a, input logic [7:0] d);
      reg_wr <= w;
      reg_rd <= r;
      reg_addr <= a;
      reg_wdata <= d;
      @(posedge clk_sys);
   endtask
   task automatic cyc(input int n);
      reg_wr <= 1'b0;
      reg_rd <= 1'b0;
      repeat (n) @(posedge clk_sys);
   endtask
   task automatic rd(input logic [7:0] a, input logic [7:0] m, input logic [7:0] x);
      q.push_back({m, x});
      bus(1'b0, 1'b1, a, 8'h00);
   endtask
   task automatic frame(input logic [3:0] l);
      // Drop any strobe left up by the previous access
      reg_wr <= 1'b0;
      reg_rd <= 1'b0;
      len <= l;
      go <= 1'b1;
      @(posedge clk_sys);
      go <= 1'b0;
      cyc(3);
      rd(8'h09, 8'h81, 8'h80);
      cyc(int'(l) + 4);
   endtask
   task automatic report_and_stop();
      if (mismatches == 0 && total_checks > 0) begin
         $display("verification passed");
      end else begin
         $display("verification failed");
      end
      $finish;
   endtask
   // Watchdog against a hung sequence
   initial begin
      #200000;
      mismatches++;
      report_and_stop();
   end
   // ----------------------------------------
   // Main sequence
   // ----------------------------------------
   initial begin
      void'($urandom(45));
      repeat (20) @(posedge clk_sys);
      rst <= 1'b0;
      bus(1'b1, 1'b0, 8'h09, 8'hff);
      for (int i = 0; i < 6; i++) rd(8'h08 + 8'(i), 8'hff, 8'h00);
      rd(8'h3f, 8'hff, 8'h00);
      slave_mode <= 1'b1;
      cyc(30);
      rd(8'h09, 8'h40, 8'h40);
      // Entering sleep drops the idle timeout flag
      sleep_mode <= 1'b1;
      cyc(2);
      rd(8'h09, 8'h40, 8'h00);
      sleep_mode <= 1'b0;
      frame(4'h2 + 4'($urandom % 8));
      rd(8'h09, 8'h11, 8'h11);
      // Long frame that the next break cuts while it is still busy
      len <= 4'h9;
      go <= 1'b1;
      cyc(1);
      go <= 1'b0;
      cyc(6);
      frame(4'h3);
      rd(8'h09, 8'h20, 8'h20);
      frame(4'h3);
      rd(8'h09, 8'h20, 8'h00);
      bus(1'b1, 1'b0, 8'h08, 8'h80);
      rd(8'h09, 8'h20, 8'h20);
      slave_mode <= 1'b0;
      bus(1'b1, 1'b0, 8'h08, 8'h80);
      frame(4'h2);
      rd(8'h09, 8'h11, 8'h01);
      slave_mode <= 1'b1;
      repeat (3) begin
         e = 5'($urandom) | 5'h01;
         errs <= e;
         cyc(1);
         errs <= 5'h00;
         cyc(1);
         rd(8'h0a, 8'hff, {3'h0, e});
         rd(8'h09, 8'h04, 8'h04);
         bus(1'b1, 1'b0, 8'h08, 8'h04);
         rd(8'h0a, 8'hff, 8'h00);
         rd(8'h09, 8'h04, 8'h00);
      end
      wake_tx <= 1'b1;
      cyc(2);
      rd(8'h09, 8'h02, 8'h02);
      wake_tx <= 1'b0;
      cyc(2);
      rd(8'h09, 8'h02, 8'h00);
      wake_rx <= 1'b1;
      cyc(1);
      wake_rx <= 1'b0;
      cyc(2);
      rd(8'h09, 8'h02, 8'h02);
      frame(4'h2);
      rd(8'h09, 8'h02, 8'h00);
      bus(1'b1, 1'b0, 8'h11, 8'h02);
      rd(8'h11, 8'h3f, 8'h02);
      frame(4'h2 + 4'($urandom % 8));
      #1 `LSF_CHK(irq, 1'b1)
      rd(8'h09, 8'h08, 8'h08);
      rd(8'h10, 8'h02, 8'h02);
      bus(1'b1, 1'b0, 8'h10, 8'h02);
      bus(1'b1, 1'b0, 8'h08, 8'h08);
      rd(8'h10, 8'h02, 8'h00);
      rd(8'h09, 8'h08, 8'h00);
      cyc(3);
      #1 `LSF_CHK(irq, 1'b0)
      report_and_stop();
   end
endmodule // lsf_status_tb
`default_nettype wire
